// [hdl/fcf_defines.svh]
`ifndef FCF_DEFINES_SVH
`define FCF_DEFINES_SVH

// Register indices; byte address is four times the index
`define FCF_IDX_CTL       6'h18
`define FCF_IDX_HIGH_MSB  6'h19
`define FCF_IDX_HIGH_LSB  6'h1a
`define FCF_IDX_LOW_MSB   6'h1b
`define FCF_IDX_LOW_LSB   6'h1c
`define FCF_IDX_LIM_MSB   6'h1d
`define FCF_IDX_LIM_LSB   6'h1e
`define FCF_IDX_RATE      6'h1f
`define FCF_IDX_FWD       6'h20
`define FCF_IDX_FNUM_LSB  6'h23
`define FCF_IDX_FNUM_MSB  6'h24

// Reset values
`define FCF_RST_ZERO      8'h00
`define FCF_RST_LIM_LSB   8'h04
`define FCF_RST_RATE      8'h02
`define FCF_RST_FWD       8'h30

// Writable bit masks
`define FCF_MASK_CTL      8'h07
`define FCF_MASK_RATE     8'h0f
`define FCF_MASK_FWD      8'hf0

// Field positions
`define FCF_CTL_EN        0
`define FCF_CTL_STYLE     1
`define FCF_CTL_RAW       2
`define FCF_FWD_PORT1     5
`define FCF_FWD_PORT0     4

// Lane rate codes
`define FCF_RATE_1600     2'b00
`define FCF_RATE_800      2'b10
`define FCF_RATE_400      2'b11

`endif

// [hdl/fcf_pkg.sv]
package fcf_pkg;

  typedef enum logic [1:0] {
    FCF_IDLE = 2'b00,
    FCF_LOW  = 2'b01,
    FCF_HIGH = 2'b10
  } fcf_phase_t;

  typedef struct packed {
    logic        start;
    logic        stop;
    logic [15:0] number;
  } fcf_frame_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  high_msb;
    logic [7:0]  high_lsb;
    logic [7:0]  low_msb;
    logic [7:0]  low_lsb;
    logic [7:0]  lim_msb;
    logic [7:0]  lim_lsb;
    logic [7:0]  rate;
    logic [7:0]  fwd;
    fcf_phase_t  phase;
    logic [23:0] cnt;
    logic        fs;
    logic [15:0] fnum;
    logic        in_frame;
    logic        start;
    logic        stop;
    logic [31:0] rdata;
  } fcf_state_t;

endpackage

// [hdl/fcf_frame_forward_ctrl.sv]
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "fcf_defines.svh"
// Contract
// - Low-period register holds count bits 7:0
// - Programmed zero gives one-cycle period
// - RAW mode frames carry 16-bit number
// - Zero limit forces frame number zero
// - Number counts from 1, wraps to 1
// - Limit split in two bytes, resets 0/4
// - Two-bit code selects lane rate, resets 10
// - Bit 5 blocks port 1, resets set
// - Bit 4 blocks port 0, resets set
// - Hi/Lo style times periods separately
// - Equal style uses one 24-bit count
module fcf_frame_forward_ctrl
  import fcf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             frame_sync_signal,
  output fcf_frame_t       frame_packet,
  output logic             raw_mode,
  output logic      [1:0]  lane_rate_code,
  output logic             first_port_forward_block,
  output logic             second_port_forward_block
);

  fcf_state_t s;
  fcf_state_t next_s;

  always_comb begin
    logic [5:0]  idx;
    logic        hit;
    logic [7:0]  rd_val;
    logic [7:0]  wd;
    logic        en;
    logic [23:0] per_high;
    logic [23:0] per_low;
    logic [15:0] lim;
    logic [15:0] num_next;
    idx      = paddr[7:2];
    hit      = 1'b0;
    rd_val   = `FCF_RST_ZERO;
    wd       = pwdata[7:0];
    en       = s.ctl[`FCF_CTL_EN];
    per_high = 24'h00_0000;
    per_low  = 24'h00_0000;
    lim      = {s.lim_msb, s.lim_lsb};
    num_next = 16'h0000;
    next_s       = s;
    next_s.start = 1'b0;
    next_s.stop  = 1'b0;

    // Address decode; misaligned or high addresses are unmapped
    if (paddr[1:0] == 2'b00 && paddr[11:8] == 4'h0) begin
      hit = 1'b1;
      case (idx)
        `FCF_IDX_CTL:      rd_val = s.ctl;
        `FCF_IDX_HIGH_MSB: rd_val = s.high_msb;
        `FCF_IDX_HIGH_LSB: rd_val = s.high_lsb;
        `FCF_IDX_LOW_MSB:  rd_val = s.low_msb;
        `FCF_IDX_LOW_LSB:  rd_val = s.low_lsb;
        `FCF_IDX_LIM_MSB:  rd_val = s.lim_msb;
        `FCF_IDX_LIM_LSB:  rd_val = s.lim_lsb;
        `FCF_IDX_RATE:     rd_val = s.rate;
        `FCF_IDX_FWD:      rd_val = s.fwd;
        `FCF_IDX_FNUM_LSB: rd_val = s.fnum[7:0];
        `FCF_IDX_FNUM_MSB: rd_val = s.fnum[15:8];
        default:           hit    = 1'b0;
      endcase
    end

    // Read data captured in setup, so prdata is a flop in access
    if (psel && !penable) begin
      next_s.rdata = {24'h00_0000, rd_val};
    end

    // Only byte lane 0 carries register bits
    if (psel && penable && pwrite && pstrb[0] && hit) begin
      case (idx)
        `FCF_IDX_CTL:      next_s.ctl      = wd & `FCF_MASK_CTL;
        `FCF_IDX_HIGH_MSB: next_s.high_msb = wd;
        `FCF_IDX_HIGH_LSB: next_s.high_lsb = wd;
        `FCF_IDX_LOW_MSB:  next_s.low_msb  = wd;
        `FCF_IDX_LOW_LSB:  next_s.low_lsb  = wd;
        `FCF_IDX_LIM_MSB:  next_s.lim_msb  = wd;
        `FCF_IDX_LIM_LSB:  next_s.lim_lsb  = wd;
        `FCF_IDX_RATE:     next_s.rate     = wd & `FCF_MASK_RATE;
        `FCF_IDX_FWD:      next_s.fwd      = wd & `FCF_MASK_FWD;
        default:           next_s.rdata    = s.rdata;
      endcase
    end

    // Equal style shares one 24-bit count for both periods
    if (s.ctl[`FCF_CTL_STYLE]) begin
      per_high = {s.high_lsb, s.low_msb, s.low_lsb};
      per_low  = {s.high_lsb, s.low_msb, s.low_lsb};
    end else begin
      per_high = {8'h00, s.high_msb, s.high_lsb};
      per_low  = {8'h00, s.low_msb, s.low_lsb};
    end

    // Wrap to 1; also covers a limit lowered below the current number
    if (lim == 16'h0000) begin
      num_next = 16'h0000;
    end else if (s.fnum == 16'h0000 || s.fnum >= lim) begin
      num_next = 16'h0001;
    end else begin
      num_next = 16'(s.fnum + 16'h0001);
    end

    case (s.phase)
      FCF_IDLE: begin
        next_s.fs  = 1'b0;
        next_s.cnt = 24'h00_0000;
        if (en) begin
          next_s.phase = FCF_LOW;
        end
      end
      FCF_LOW: begin
        if (!en) begin
          next_s.phase = FCF_IDLE;
          next_s.cnt   = 24'h00_0000;
        end else if (s.cnt == per_low) begin
          // Count of N holds the level N plus one cycles
          next_s.cnt   = 24'h00_0000;
          next_s.phase = FCF_HIGH;
          next_s.fs    = 1'b1;
          next_s.fnum  = num_next;
          if (s.ctl[`FCF_CTL_RAW]) begin
            next_s.start    = 1'b1;
            next_s.in_frame = 1'b1;
          end
        end else begin
          next_s.cnt = 24'(s.cnt + 24'h00_0001);
        end
      end
      FCF_HIGH: begin
        if (!en || s.cnt == per_high) begin
          next_s.cnt   = 24'h00_0000;
          next_s.phase = en ? FCF_LOW : FCF_IDLE;
          next_s.fs    = 1'b0;
          // End packet closes only a frame that had a start
          if (s.in_frame) begin
            next_s.stop     = 1'b1;
            next_s.in_frame = 1'b0;
          end
        end else begin
          next_s.cnt = 24'(s.cnt + 24'h00_0001);
        end
      end
      default: begin
        next_s.phase = FCF_IDLE;
        next_s.fs    = 1'b0;
        next_s.cnt   = 24'h00_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.lim_lsb  <= `FCF_RST_LIM_LSB;
      s.rate     <= `FCF_RST_RATE;
      s.fwd      <= `FCF_RST_FWD;
      s.phase    <= FCF_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave; error only on unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = psel && penable &&
                   !(paddr[1:0] == 2'b00 && paddr[11:8] == 4'h0 &&
                     ((paddr[7:2] >= `FCF_IDX_CTL &&
                       paddr[7:2] <= `FCF_IDX_FWD) ||
                      paddr[7:2] == `FCF_IDX_FNUM_LSB ||
                      paddr[7:2] == `FCF_IDX_FNUM_MSB));
  assign prdata  = s.rdata;

  assign frame_sync_signal         = s.fs;
  assign frame_packet.start        = s.start;
  assign frame_packet.stop         = s.stop;
  assign frame_packet.number       = s.fnum;
  assign raw_mode                  = s.ctl[`FCF_CTL_RAW];
  assign lane_rate_code            = s.rate[1:0];
  assign second_port_forward_block = s.fwd[`FCF_FWD_PORT1];
  assign first_port_forward_block  = s.fwd[`FCF_FWD_PORT0];

endmodule

// [tb/fcf_properties.sv]
`timescale 1ns/1ps
module fcf_props
  import fcf_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        frame_sync_signal,
  input wire fcf_frame_t  frame_packet,
  input wire logic        raw_mode,
  input wire logic [1:0]  lane_rate_code,
  input wire logic        first_port_forward_block,
  input wire logic        second_port_forward_block
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  rate_write_a: assert property (wr && paddr == 12'h07c |=>
    lane_rate_code == $past(pwdata[1:0])) else $error("rate lost");
  port_one_a: assert property (wr && paddr == 12'h080 |=>
    second_port_forward_block == $past(pwdata[5])) else $error("p1");
  port_zero_a: assert property (wr && paddr == 12'h080 |=>
    first_port_forward_block == $past(pwdata[4])) else $error("p0");
  reset_state_a: assert property ($rose(presetn) |->
    lane_rate_code == 2'b10 && first_port_forward_block
    && second_port_forward_block) else $error("bad reset state");
  start_rise_a: assert property (frame_packet.start |->
    $rose(frame_sync_signal) && $past(raw_mode)) else $error("start off");
  stop_fall_a: assert property (frame_packet.stop |->
    $fell(frame_sync_signal) && $stable(frame_packet.number))
    else $error("stop off");
  number_hold_a: assert property (raw_mode && $past(raw_mode) &&
    !frame_packet.start |-> $stable(frame_packet.number))
    else $error("number moved");
  number_step_a: assert property (frame_packet.start &&
    frame_packet.number > 16'h0001 |->
    frame_packet.number == $past(frame_packet.number) + 16'h0001)
    else $error("number skipped");
endmodule

bind fcf_frame_forward_ctrl fcf_props fcf_props_i (.*);

// [tb/fcf_sink.sv]
`timescale 1ns/1ps
module fcf_sink
  import fcf_pkg::*;
(
  input wire logic       pclk,
  input wire fcf_frame_t frame_packet,
  output int             frames,
  output int             bad
);
  logic [15:0] num;
  initial frames = 0;
  initial bad = 0;
  always @(negedge pclk) begin
    if (frame_packet.start) begin
      frames++;
      num = frame_packet.number;
    end
    if (frame_packet.stop && frame_packet.number !== num) bad++;
  end
endmodule

// [tb/fcf_frame_forward_ctrl_tb_top.sv]
`timescale 1ns/1ps
module fcf_frame_forward_ctrl_tb_top
  import fcf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  logic [3:0]  pstrb;
  logic        frame_sync_signal, raw_mode;
  logic        first_port_forward_block, second_port_forward_block;
  logic [1:0]  lane_rate_code;
  fcf_frame_t  frame_packet;
  int          fail_count, check_count, g, frames, bad;
  logic [11:0] ra [5] = '{12'h070, 12'h074, 12'h078, 12'h07c, 12'h080};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h30};
  logic [7:0]  rc [3] = '{8'h00, 8'h03, 8'h02};
  logic [7:0]  fw [3] = '{8'h10, 8'h20, 8'h00};

  fcf_frame_forward_ctrl fcf_frame_forward_ctrl_i (.*);
  fcf_sink fcf_sink_i (.*);

  always #20 pclk = ~pclk;

  task give_verdict;
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge, giving up after 20 more edges
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Gap to next start pulse, capped so a dead generator cannot hang us
  task wait_start;
    g = 0;
    do @(negedge pclk); while (!frame_packet.start && ++g < 20);
    g++;
  endtask

  initial begin
    #100_000;
    fail_count++;
    give_verdict;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite} = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hf;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(32'({second_port_forward_block, first_port_forward_block,
      lane_rate_code}), 32'h0000_000e);
    foreach (ra[i]) begin
      apb(0, ra[i], 8'h00);
      chk(r, 32'(rv[i]));
    end
    foreach (rc[i]) begin
      apb(1, 12'h07c, rc[i]);
      @(negedge pclk);
      chk(32'(lane_rate_code), 32'(rc[i][1:0]));
    end
    apb(1, 12'h07c, 8'hff);
    apb(0, 12'h07c, 8'h00);
    chk(r, 32'h0000_000f);
    foreach (fw[i]) begin
      apb(1, 12'h080, fw[i]);
      @(negedge pclk);
      chk(32'({second_port_forward_block, first_port_forward_block}),
        32'(fw[i][5:4]));
    end
    apb(0, 12'h084, 8'h00);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(0, 12'h070, 8'h00);
    chk(32'(e), 32'h0000_0000);
    pstrb <= 4'h0;
    apb(1, 12'h070, 8'h5a);
    pstrb <= 4'hf;
    apb(0, 12'h070, 8'h00);
    chk(r, 32'h0000_0000);
    apb(1, 12'h070, 8'ha5);
    apb(0, 12'h070, 8'h00);
    chk(r, 32'h0000_00a5);
    apb(1, 12'h070, 8'h00);
    apb(1, 12'h060, 8'h05);
    for (int i = 0; i < 6; i++) begin
      wait_start;
      chk(32'(frame_packet.number), 32'(i % 4 + 1));
    end
    wait_start;
    chk(32'(g), 32'h0000_0002);
    apb(1, 12'h070, 8'h02);
    wait_start;
    wait_start;
    chk(32'(g), 32'h0000_0004);
    apb(1, 12'h078, 8'h00);
    wait_start;
    chk(32'(frame_packet.number), 32'h0000_0000);
    apb(1, 12'h074, 8'h01);
    repeat (5) wait_start;
    chk(32'(frame_packet.number), 32'h0000_0005);
    apb(1, 12'h060, 8'h07);
    wait_start;
    wait_start;
    chk(32'(g), 32'h0000_0006);
    apb(1, 12'h060, 8'h01);
    wait_start;
    chk(32'(g), 32'h0000_0015);
    chk(32'(bad), 32'h0000_0000);
    chk(32'(frames > 10), 32'h0000_0001);
    give_verdict;
  end
endmodule
